// ### src/sdpci_device.sv
// Memory device end: command decode, banks, bursts, masks and power states.
// Assumes the controller end drives the pins on the same core clock.
`timescale 1ns/1ps
`include "sdpci_consts.svh"

// Operation
// - Sample all inputs on rising clock edge
// - Row address 12 bits, column 8 bits
// - Precharge all banks when select bit set
// - Bank index names bank for row/column
// - Chip select high ignores new commands
// - Strobe levels decode the operation
// - Read mask blanks lane two cycles later
// - Write mask discards lane data immediately
// - Clock gate low enters low-power states
// - Data lines shared, both directions
// - Read is column strobe low alone
// - Write data starts with write command
// - All strobes low loads mode settings
// - One mask bit per data byte
module sdpci_device
    import sdpci_pkg::*;
(
    // Clock and reset
    input  wire logic                       core_clk_in,
    input  wire logic                       nrst_in,
    // Pins
    sdpci_if.dev                            pins,
    // Status
    output logic      [`SDPCI_BANK_W*2-1:0] open_banks_out,
    output sdpci_pwr_type                   pwr_state_out,
    output logic      [`SDPCI_ADDR_W-1:0]   mode_reg_out
);
    //------------------------------------------------------------
    // Input capture
    //------------------------------------------------------------
    logic                       cke_q;
    logic                       cmd_valid_q;
    logic [2:0]                 cmd_q;
    logic [`SDPCI_ADDR_W-1:0]   addr_q;
    logic [`SDPCI_BANK_W-1:0]   bank_q;
    logic [`SDPCI_DATA_W-1:0]   wdata_q;
    logic [`SDPCI_LANES-1:0]    mask_q;
    logic                       clk_en;
    sdpci_op_type               op;

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cke_q       <= 1'b0;
            cmd_valid_q <= 1'b0;
            cmd_q       <= `SDPCI_CMD_NOP;
            addr_q      <= '0;
            bank_q      <= '0;
            wdata_q     <= '0;
            mask_q      <= '1;
        end else begin
            cke_q       <= pins.clk_gate;
            cmd_valid_q <= ~pins.chip_sel_n & pins.clk_gate;
            cmd_q       <= {pins.row_strobe_n, pins.col_strobe_n, pins.write_strobe_n};
            addr_q      <= pins.multiplexed_row_col_addr;
            bank_q      <= pins.bank_index;
            wdata_q     <= pins.bidir_data_bus;
            mask_q      <= pins.byte_lane_mask;
        end
    end

    assign clk_en = cke_q;
    assign op = cmd_valid_q ? sdpci_op_type'(cmd_q) : SDPCI_OP_NOP;

    //------------------------------------------------------------
    // Banks, rows and mode
    //------------------------------------------------------------
    logic [`SDPCI_LANES-1:0]    bank_open_q;
    logic [`SDPCI_ADDR_W-1:0]   row_q [`SDPCI_LANES];
    logic [`SDPCI_ADDR_W-1:0]   mode_q;

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bank_open_q <= '0;
            mode_q      <= '0;
            for (int i = 0; i < `SDPCI_LANES; i++) begin
                row_q[i] <= '0;
            end
        end else if (clk_en) begin
            case (op)
                SDPCI_OP_ACT: begin
                    bank_open_q[bank_q] <= 1'b1;
                    row_q[bank_q]       <= addr_q;
                end
                SDPCI_OP_PRE: begin
                    if (addr_q[`SDPCI_ALL_BANK_BIT]) begin
                        bank_open_q <= '0;
                    end else begin
                        bank_open_q[bank_q] <= 1'b0;
                    end
                end
                SDPCI_OP_MRS: begin
                    mode_q <= addr_q;
                end
                default: begin
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // Burst engine
    //------------------------------------------------------------
    localparam int MEM_WORDS = `SDPCI_LANES * `SDPCI_ROWS * (1 << `SDPCI_COL_W);
    logic [`SDPCI_DATA_W-1:0]   rd_word;
    logic                       rd_act_q;
    logic                       wr_act_q;
    logic [`SDPCI_COL_W-1:0]    col_q;
    logic [`SDPCI_BANK_W-1:0]   bbank_q;
    logic [2:0]                 left_q;
    logic [`SDPCI_COL_W-1:0]    col_now;
    logic [`SDPCI_BANK_W-1:0]   bank_now;
    logic                       wr_now;
    logic                       rd_now;
    logic [$clog2(MEM_WORDS)-1:0] idx;
    logic [`SDPCI_LANES-1:0]    rd_lane_on;
    logic [`SDPCI_LANES-1:0]    wr_lane_en;

    assign wr_now   = (op == SDPCI_OP_WR) | (wr_act_q & ~(op == SDPCI_OP_RD));
    assign rd_now   = (op == SDPCI_OP_RD) | (rd_act_q & ~(op == SDPCI_OP_WR));
    assign col_now  = (op == SDPCI_OP_WR || op == SDPCI_OP_RD) ?
                      addr_q[`SDPCI_COL_W-1:0] : col_q;
    assign bank_now = (op == SDPCI_OP_WR || op == SDPCI_OP_RD) ? bank_q : bbank_q;
    assign idx      = {bank_now, row_q[bank_now][$clog2(`SDPCI_ROWS)-1:0], col_now};

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            col_q    <= '0;
            bbank_q  <= '0;
            left_q   <= '0;
        end else if (clk_en) begin
            if (op == SDPCI_OP_RD || op == SDPCI_OP_WR) begin
                rd_act_q <= (op == SDPCI_OP_RD) && (`SDPCI_BURST_LEN > 1);
                wr_act_q <= (op == SDPCI_OP_WR) && (`SDPCI_BURST_LEN > 1);
                left_q   <= 3'(`SDPCI_BURST_LEN - 1);
                col_q    <= col_now + 8'h01;
                bbank_q  <= bank_q;
            end else if (op == SDPCI_OP_BST || op == SDPCI_OP_PRE || left_q <= 3'h1) begin
                rd_act_q <= 1'b0;
                wr_act_q <= 1'b0;
                left_q   <= '0;
            end else if (rd_act_q || wr_act_q) begin
                left_q   <= left_q - 3'h1;
                col_q    <= col_q + 8'h01;
            end
        end
    end

    sdpci_lane_mask u_mask (
        .core_clk_in     (core_clk_in),
        .nrst_in         (nrst_in),
        .clk_en_in       (clk_en),
        .mask_in         (mask_q),
        .read_active_in  (rd_now),
        .write_active_in (wr_now),
        .rd_lane_on_out  (rd_lane_on),
        .wr_lane_en_out  (wr_lane_en)
    );

    genvar g;
    generate
        for (g = 0; g < `SDPCI_LANES; g++) begin : g_wr
            logic [7:0] mem_lane [MEM_WORDS];
            always_ff @(posedge core_clk_in) begin
                if (clk_en && wr_lane_en[g]) begin
                    mem_lane[idx] <= wdata_q[g*8 +: 8];
                end
            end
            assign rd_word[g*8 +: 8] = mem_lane[idx];
        end
    endgenerate

    //------------------------------------------------------------
    // Read data pipeline
    //------------------------------------------------------------
    logic [`SDPCI_DATA_W-1:0]   rpipe_q [`SDPCI_CAS_LAT];
    logic [`SDPCI_CAS_LAT-1:0]  rvld_q;

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rvld_q <= '0;
            for (int i = 0; i < `SDPCI_CAS_LAT; i++) begin
                rpipe_q[i] <= '0;
            end
        end else if (clk_en) begin
            rvld_q     <= {rvld_q[`SDPCI_CAS_LAT-2:0], rd_now};
            rpipe_q[0] <= rd_word;
            for (int i = 1; i < `SDPCI_CAS_LAT; i++) begin
                rpipe_q[i] <= rpipe_q[i-1];
            end
        end
    end

    assign pins.dev_data    = rpipe_q[`SDPCI_CAS_LAT-1];
    assign pins.dev_data_oe = {`SDPCI_LANES{rvld_q[`SDPCI_CAS_LAT-1]}} & rd_lane_on;

    //------------------------------------------------------------
    // Power states
    //------------------------------------------------------------
    sdpci_pwr_type pwr_q;
    logic          cke_prev_q;
    logic          ref_last_q;

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pwr_q      <= SDPCI_PWR_RUN;
            cke_prev_q <= 1'b0;
            ref_last_q <= 1'b0;
        end else begin
            cke_prev_q <= cke_q;
            ref_last_q <= clk_en ? (op == SDPCI_OP_REF) : ref_last_q;
            case (pwr_q)
                SDPCI_PWR_RUN: begin
                    if (cke_prev_q && !cke_q) begin
                        if (ref_last_q) begin
                            pwr_q <= SDPCI_PWR_SELF_REF;
                        end else if (rd_act_q || wr_act_q) begin
                            pwr_q <= SDPCI_PWR_SUSPEND;
                        end else begin
                            pwr_q <= SDPCI_PWR_DOWN;
                        end
                    end
                end
                default: begin
                    if (cke_q) begin
                        pwr_q <= SDPCI_PWR_RUN;
                    end
                end
            endcase
        end
    end

    assign pwr_state_out  = pwr_q;
    assign mode_reg_out   = mode_q;
    assign open_banks_out = bank_open_q;
endmodule

// ### src/sdpci_consts.svh
// Constants of the SDRAM pin command interface: widths, command codes, latencies.
// Assumes inclusion by bare name from the package and from the design modules.
`ifndef SDPCI_CONSTS_SVH
`define SDPCI_CONSTS_SVH

`define SDPCI_ADDR_W        12
`define SDPCI_COL_W         8
`define SDPCI_BANK_W        2
`define SDPCI_DATA_W        32
`define SDPCI_LANES         4
`define SDPCI_ALL_BANK_BIT  10
`define SDPCI_MASK_RD_LAT   2
`define SDPCI_CAS_LAT       2
`define SDPCI_BURST_LEN     4
`define SDPCI_ROWS          8

// Command code {row strobe, column strobe, write strobe}, active low
`define SDPCI_CMD_MRS       3'h0
`define SDPCI_CMD_REF       3'h1
`define SDPCI_CMD_PRE       3'h2
`define SDPCI_CMD_ACT       3'h3
`define SDPCI_CMD_WR        3'h4
`define SDPCI_CMD_RD        3'h5
`define SDPCI_CMD_BST       3'h6
`define SDPCI_CMD_NOP       3'h7

`endif

// ### src/sdpci_pkg.sv
// Types shared by both ends of the SDRAM pin command interface.
// Assumes sdpci_consts.svh is on the include path.
`include "sdpci_consts.svh"

package sdpci_pkg;
    typedef enum logic [2:0] {
        SDPCI_OP_MRS,
        SDPCI_OP_REF,
        SDPCI_OP_PRE,
        SDPCI_OP_ACT,
        SDPCI_OP_WR,
        SDPCI_OP_RD,
        SDPCI_OP_BST,
        SDPCI_OP_NOP
    } sdpci_op_type;

    typedef enum logic [1:0] {
        SDPCI_PWR_RUN,
        SDPCI_PWR_DOWN,
        SDPCI_PWR_SUSPEND,
        SDPCI_PWR_SELF_REF
    } sdpci_pwr_type;
endpackage

// ### src/sdpci_if.sv
// Pin bundle between the memory controller end and the memory device end.
// Assumes the testbench resolves the shared data bus from the two enables.
`timescale 1ns/1ps
`include "sdpci_consts.svh"

interface sdpci_if;
    logic                           clk_gate;
    logic                           chip_sel_n;
    logic                           row_strobe_n;
    logic                           col_strobe_n;
    logic                           write_strobe_n;
    logic [`SDPCI_ADDR_W-1:0]       multiplexed_row_col_addr;
    logic [`SDPCI_BANK_W-1:0]       bank_index;
    logic [`SDPCI_LANES-1:0]        byte_lane_mask;
    logic [`SDPCI_DATA_W-1:0]       ctl_data;
    logic                           ctl_data_oe;
    logic [`SDPCI_DATA_W-1:0]       dev_data;
    logic [`SDPCI_LANES-1:0]        dev_data_oe;
    logic [`SDPCI_DATA_W-1:0]       bidir_data_bus;

    modport ctl (
        output clk_gate, chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n,
        output multiplexed_row_col_addr, bank_index, byte_lane_mask,
        output ctl_data, ctl_data_oe,
        input  bidir_data_bus
    );
    modport dev (
        input  clk_gate, chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n,
        input  multiplexed_row_col_addr, bank_index, byte_lane_mask,
        output dev_data, dev_data_oe,
        input  bidir_data_bus
    );
endinterface

// ### src/sdpci_lane_mask.sv
// Per-lane read mask pipeline and write lane enables.
// Assumes inputs are already captured on the rising clock edge.
`timescale 1ns/1ps
`include "sdpci_consts.svh"

module sdpci_lane_mask
    import sdpci_pkg::*;
(
    // Clock and reset
    input  wire logic                       core_clk_in,
    input  wire logic                       nrst_in,
    // Masks
    input  wire logic                       clk_en_in,
    input  wire logic [`SDPCI_LANES-1:0]    mask_in,
    input  wire logic                       read_active_in,
    input  wire logic                       write_active_in,
    // Lane controls
    output logic      [`SDPCI_LANES-1:0]    rd_lane_on_out,
    output logic      [`SDPCI_LANES-1:0]    wr_lane_en_out
);
    genvar g;
    generate
        for (g = 0; g < `SDPCI_LANES; g++) begin : g_lane
            logic [`SDPCI_MASK_RD_LAT-1:0] mask_q;
            always_ff @(posedge core_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    mask_q <= '1;
                end else if (clk_en_in) begin
                    mask_q <= {mask_q[`SDPCI_MASK_RD_LAT-2:0], mask_in[g]};
                end
            end
            assign rd_lane_on_out[g] = ~mask_q[`SDPCI_MASK_RD_LAT-1];
            assign wr_lane_en_out[g] = write_active_in & ~mask_in[g];
        end
    endgenerate

    logic unused_rd;
    assign unused_rd = read_active_in;
endmodule

// ### src/sdpci_controller.sv
// Memory controller end: issues one command per request and drives write data.
// Assumes the device end shares core_clk_in; requests are one-cycle pulses.
`timescale 1ns/1ps
`include "sdpci_consts.svh"

module sdpci_controller
    import sdpci_pkg::*;
(
    // Clock and reset
    input  wire logic                       core_clk_in,
    input  wire logic                       nrst_in,
    // Pins
    sdpci_if.ctl                            pins,
    // User request
    input  wire logic                       req_valid_in,
    output logic                            req_ready_out,
    input  wire sdpci_op_type               req_op_in,
    input  wire logic [`SDPCI_ADDR_W-1:0]   req_addr_in,
    input  wire logic [`SDPCI_BANK_W-1:0]   req_bank_in,
    input  wire logic                       clk_gate_in,
    // Write data, one word per cycle of a write burst
    input  wire logic [`SDPCI_DATA_W-1:0]   wr_data_in,
    input  wire logic [`SDPCI_LANES-1:0]    wr_mask_in,
    // Read data
    output logic      [`SDPCI_DATA_W-1:0]   rd_data_out
);
    logic [2:0]                 wleft_q;
    logic                       cs_n_q;
    logic [2:0]                 cmd_q;
    logic [`SDPCI_ADDR_W-1:0]   addr_q;
    logic [`SDPCI_BANK_W-1:0]   bank_q;
    logic [`SDPCI_LANES-1:0]    mask_q;
    logic [`SDPCI_DATA_W-1:0]   wdata_q;
    logic                       oe_q;
    logic                       gate_q;
    logic                       take;

    assign req_ready_out = (wleft_q == 3'h0);
    assign take          = req_valid_in & req_ready_out;

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cs_n_q  <= 1'b1;
            cmd_q   <= `SDPCI_CMD_NOP;
            addr_q  <= '0;
            bank_q  <= '0;
            gate_q  <= 1'b1;
        end else begin
            gate_q  <= clk_gate_in;
            cs_n_q  <= ~take;
            cmd_q   <= take ? 3'(req_op_in) : `SDPCI_CMD_NOP;
            addr_q  <= take ? req_addr_in : addr_q;
            bank_q  <= take ? req_bank_in : bank_q;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wleft_q <= '0;
            oe_q    <= 1'b0;
            wdata_q <= '0;
            mask_q  <= '1;
        end else begin
            if (take && req_op_in == SDPCI_OP_WR) begin
                wleft_q <= 3'(`SDPCI_BURST_LEN - 1);
                oe_q    <= 1'b1;
            end else if (wleft_q != 3'h0) begin
                wleft_q <= wleft_q - 3'h1;
                oe_q    <= 1'b1;
            end else begin
                oe_q    <= 1'b0;
            end
            wdata_q <= wr_data_in;
            mask_q  <= wr_mask_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= pins.bidir_data_bus;
        end
    end

    assign pins.clk_gate                 = gate_q;
    assign pins.chip_sel_n               = cs_n_q;
    assign pins.row_strobe_n             = cmd_q[2];
    assign pins.col_strobe_n             = cmd_q[1];
    assign pins.write_strobe_n           = cmd_q[0];
    assign pins.multiplexed_row_col_addr = addr_q;
    assign pins.bank_index               = bank_q;
    assign pins.byte_lane_mask           = mask_q;
    assign pins.ctl_data                 = wdata_q;
    assign pins.ctl_data_oe              = oe_q;
endmodule

// ### test/sdpci_properties.sv
// Concurrent checks on the pins that join the controller end and the device end.
// Assumes instantiation beside the interface, each input tied to its signal by name.
`timescale 1ns/1ps
`include "sdpci_consts.svh"

module sdpci_properties
    import sdpci_pkg::*;
(
    // Clock and reset
    input  wire logic                       core_clk_in,
    input  wire logic                       nrst_in,
    // Command pins
    input  wire logic                       clk_gate,
    input  wire logic                       chip_sel_n,
    input  wire logic                       row_strobe_n,
    input  wire logic                       col_strobe_n,
    input  wire logic                       write_strobe_n,
    input  wire logic [`SDPCI_LANES-1:0]    byte_lane_mask,
    // Data enables
    input  wire logic                       ctl_data_oe,
    input  wire logic [`SDPCI_LANES-1:0]    dev_data_oe
);
    wire logic cmd_ok = !chip_sel_n && clk_gate;
    wire logic rd_cmd = cmd_ok && row_strobe_n && !col_strobe_n && write_strobe_n;
    wire logic wr_cmd = cmd_ok && row_strobe_n && !col_strobe_n && !write_strobe_n;
    wire logic any_oe = |dev_data_oe;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    AST_NO_CONTENTION: assert property (!(ctl_data_oe && any_oe))
        else $error("both ends drive the data bus");
    AST_WR_DATA_WINDOW: assert property (wr_cmd |-> ctl_data_oe [*4])
        else $error("write data not driven through the burst");
    AST_WR_DATA_END: assert property ($fell(ctl_data_oe) |-> $past(wr_cmd, 4))
        else $error("write data released at the wrong cycle");
    AST_RD_START: assert property (rd_cmd ##1 clk_gate |-> ##2 any_oe)
        else $error("read data did not start");
    AST_RD_ORIGIN: assert property ($rose(any_oe) && $past(clk_gate)
        && $past(clk_gate, 2) && $past(clk_gate, 3) |-> $past(rd_cmd, 3) || $past(rd_cmd, 4))
        else $error("read data without a read command");
    AST_RD_BURST_LEN: assert property ($fell(any_oe) |-> $past(any_oe, 4))
        else $error("read burst shorter than four words");
    AST_RD_MASK_HIZ: assert property ((dev_data_oe & $past(byte_lane_mask, 2)
        & $past(byte_lane_mask, 3)) == 4'h0)
        else $error("masked lane still driven");
    AST_GATE_FREEZE: assert property (!clk_gate && !$past(clk_gate)
        && !$past(clk_gate, 2) && !$past(clk_gate, 3) |-> $stable(dev_data_oe))
        else $error("device output moved while clock gated");
endmodule

// ### test/sdram_pin_command_interface_bench.sv
// Self-checking bench joining the controller end to the device end.
// Assumes the design sources and sdpci_properties are compiled first.
`timescale 1ns/1ps
`include "sdpci_consts.svh"

module sdram_pin_command_interface_bench
    import sdpci_pkg::*;
;
    logic                core_clk_in;
    logic                nrst_in;
    logic                req_valid_in;
    logic                req_ready_out;
    sdpci_op_type        req_op_in;
    logic [11:0]         req_addr_in;
    logic [1:0]          req_bank_in;
    logic                clk_gate_in;
    logic [31:0]         wr_data_in;
    logic [3:0]          wr_mask_in;
    logic [31:0]         rd_data_out;
    logic [3:0]          open_banks_out;
    sdpci_pwr_type       pwr_state_out;
    logic [11:0]         mode_reg_out;
    logic [31:0]         idle_pat;
    logic [31:0]         exp_mem [4];
    int                  bad_count;
    int                  num_checks;

    sdpci_if bus_if ();

    sdpci_controller u_sdpci_controller (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .pins(bus_if.ctl), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
        .req_op_in(req_op_in), .req_addr_in(req_addr_in), .req_bank_in(req_bank_in),
        .clk_gate_in(clk_gate_in), .wr_data_in(wr_data_in), .wr_mask_in(wr_mask_in),
        .rd_data_out(rd_data_out));
    sdpci_device u_sdpci_device (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .pins(bus_if.dev), .open_banks_out(open_banks_out), .pwr_state_out(pwr_state_out),
        .mode_reg_out(mode_reg_out));
    sdpci_properties u_sdpci_properties (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .clk_gate(bus_if.clk_gate), .chip_sel_n(bus_if.chip_sel_n),
        .row_strobe_n(bus_if.row_strobe_n), .col_strobe_n(bus_if.col_strobe_n),
        .write_strobe_n(bus_if.write_strobe_n), .byte_lane_mask(bus_if.byte_lane_mask),
        .ctl_data_oe(bus_if.ctl_data_oe), .dev_data_oe(bus_if.dev_data_oe));

    // ------------------------------------------------------------------
    // Clock and shared bus
    // ------------------------------------------------------------------
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    // Undriven lanes carry a pattern that flips every cycle
    always @(posedge core_clk_in) idle_pat <= ~idle_pat;
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            if (bus_if.ctl_data_oe) bus_if.bidir_data_bus[8*g+:8] = bus_if.ctl_data[8*g+:8];
            else if (bus_if.dev_data_oe[g])
                bus_if.bidir_data_bus[8*g+:8] = bus_if.dev_data[8*g+:8];
            else bus_if.bidir_data_bus[8*g+:8] = idle_pat[8*g+:8];
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Holds the request until taken; returns on the taking edge
    task automatic issue(input sdpci_op_type op, input logic [11:0] a, input logic [1:0] b,
                         input logic [31:0] d, input logic [3:0] m);
        logic ok;
        @(posedge core_clk_in);
        req_valid_in <= 1'b1;
        req_op_in <= op;
        req_addr_in <= a;
        req_bank_in <= b;
        wr_data_in <= d;
        wr_mask_in <= m;
        repeat (50) begin
            #1 ok = req_ready_out;
            @(posedge core_clk_in);
            if (ok === 1'b1) break;
        end
        req_valid_in <= 1'b0;
    endtask

    task automatic settle();
        repeat (4) @(posedge core_clk_in);
        @(negedge core_clk_in);
    endtask

    task automatic wr(input logic [7:0] col, input logic [31:0] base, input logic [3:0] m);
        logic [31:0] w;
        issue(SDPCI_OP_WR, {4'h0, col}, 2'h1, base, m);
        for (int k = 0; k < 4; k++) begin
            w = base + 32'h0101_0101 * k;
            for (int g = 0; g < 4; g++) if (!m[g]) exp_mem[k][8*g+:8] = w[8*g+:8];
            if (k > 0) begin
                wr_data_in <= w;
                @(posedge core_clk_in);
            end
        end
    endtask

    task automatic rd(input logic [7:0] col, input logic [3:0] m);
        int n;
        issue(SDPCI_OP_RD, {4'h0, col}, 2'h1, 32'h0000_0000, m);
        n = 0;
        while (bus_if.dev_data_oe === 4'h0 && n < 10) begin
            @(negedge core_clk_in);
            n++;
        end
        check("read start", n < 10, 32'h1);
        for (int k = 0; k < 4; k++) begin
            for (int g = 0; g < 4; g++) begin
                if (m[g]) check("masked lane oe", bus_if.dev_data_oe[g], 32'h0);
                else check("read lane", bus_if.bidir_data_bus[8*g+:8],
                           exp_mem[k][8*g+:8]);
            end
            @(negedge core_clk_in);
        end
        if (m == 4'h0) check("rd_data_out", rd_data_out, exp_mem[3]);
    endtask

    // Caller stands on a rising edge
    task automatic gate_cycle(input sdpci_pwr_type exp);
        int n;
        clk_gate_in <= 1'b0;
        n = 0;
        while (pwr_state_out === SDPCI_PWR_RUN && n < 10) begin
            @(negedge core_clk_in);
            n++;
        end
        check("power state", pwr_state_out, exp);
        repeat (4) @(posedge core_clk_in);
        clk_gate_in <= 1'b1;
        n = 0;
        while (pwr_state_out !== SDPCI_PWR_RUN && n < 10) begin
            @(negedge core_clk_in);
            n++;
        end
        check("power run", pwr_state_out, SDPCI_PWR_RUN);
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    task automatic t_mode();
        for (int i = 0; i < 2; i++) begin
            issue(SDPCI_OP_MRS, i ? 12'h031 : 12'h022, 2'h0, 32'h0, 4'h0);
            settle();
            check("mode_reg", mode_reg_out, i ? 12'h031 : 12'h022);
        end
        issue(SDPCI_OP_BST, 12'h0FF, 2'h0, 32'h0, 4'h0);
        issue(SDPCI_OP_NOP, 12'h0EE, 2'h0, 32'h0, 4'h0);
        settle();
        check("mode kept", mode_reg_out, 12'h031);
        check("banks kept", open_banks_out, 4'h0);
        $display("test mode finished");
    endtask

    task automatic t_banks();
        issue(SDPCI_OP_ACT, 12'h005, 2'h0, 32'h0, 4'h0);
        issue(SDPCI_OP_ACT, 12'h006, 2'h2, 32'h0, 4'h0);
        settle();
        check("open banks", open_banks_out, 4'h5);
        issue(SDPCI_OP_PRE, 12'h000, 2'h0, 32'h0, 4'h0);
        settle();
        check("one bank closed", open_banks_out, 4'h4);
        issue(SDPCI_OP_ACT, 12'h007, 2'h1, 32'h0, 4'h0);
        issue(SDPCI_OP_PRE, 12'h400, 2'h1, 32'h0, 4'h0);
        settle();
        check("all banks closed", open_banks_out, 4'h0);
        $display("test banks finished");
    endtask

    task automatic t_data();
        issue(SDPCI_OP_ACT, 12'h003, 2'h1, 32'h0, 4'h0);
        settle();
        wr(8'hC4, 32'h1020_3040, 4'h0);
        wr(8'hC4, 32'hA0B0_C0D0, 4'h2);
        settle();
        rd(8'hC4, 4'h8);
        rd(8'hC4, 4'h0);
        $display("test data finished");
    endtask

    task automatic t_power();
        @(posedge core_clk_in);
        gate_cycle(SDPCI_PWR_DOWN);
        issue(SDPCI_OP_REF, 12'h000, 2'h0, 32'h0, 4'h0);
        gate_cycle(SDPCI_PWR_SELF_REF);
        issue(SDPCI_OP_RD, 12'h0C4, 2'h1, 32'h0, 4'h0);
        gate_cycle(SDPCI_PWR_SUSPEND);
        repeat (8) @(posedge core_clk_in);
        check("suspended burst ends", bus_if.dev_data_oe, 4'h0);
        $display("test power finished");
    endtask

    // ------------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        nrst_in = 1'b0;
        req_valid_in = 1'b0;
        req_op_in = SDPCI_OP_NOP;
        req_addr_in = 12'h000;
        req_bank_in = 2'h0;
        clk_gate_in = 1'b1;
        wr_data_in = 32'h0000_0000;
        wr_mask_in = 4'h0;
        idle_pat = 32'hA5A5_5A5A;
        bad_count = 0;
        num_checks = 0;
        repeat (8) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        t_mode();
        t_banks();
        t_data();
        t_power();
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge core_clk_in);
        bad_count++;
        $display("[FAIL] watchdog expected end seen hang");
        stop_test();
    end
endmodule
